// *** verilog/ccs_defs.vh ***
// Register offsets, field positions and reset values of the converter command/status bank
`ifndef CCS_DEFS_VH
`define CCS_DEFS_VH

`define CCS_ADDR_CH2_CMD     8'h04
`define CCS_ADDR_CH3_CMD     8'h05
`define CCS_ADDR_STATUS      8'h06

`define CCS_RST_CH2_CMD      8'h00
`define CCS_RST_CH3_CMD      8'h00
`define CCS_RST_STATUS       8'h00
`define CCS_RST_CODE         7'h00
`define CCS_RD_UNMAPPED      8'h00

`define CCS_F_DISABLE        0
`define CCS_F_LIGHT_LOAD     1
`define CCS_F_SLEW_LO        4
`define CCS_F_SLEW_HI        6

`define CCS_ST_OVERTEMP      7
`define CCS_ST_OC3           6
`define CCS_ST_OC2           5
`define CCS_ST_OC1           4
`define CCS_ST_TEMP_WARN     3
`define CCS_ST_PG3           2
`define CCS_ST_PG2           1
`define CCS_ST_PG1           0

`define CCS_STEPCNT_W        7
`define CCS_STEPCNT_ZERO     7'h00
`define CCS_STEPCNT_ONE      7'h01
`define CCS_CODE_ONE         7'h01

`endif

// *** verilog/ccs_regs.v ***
// Command and status register bank with paced voltage-code stepping for channel two
`timescale 1ns/10ps
`include "ccs_defs.vh"

module ccs_regs (
  input  wire       mclk,
  input  wire       rst_n,
  input  wire       wr_apply,
  input  wire [7:0] reg_addr,
  input  wire [7:0] wr_data,
  input  wire       rd_req,
  input  wire [6:0] voltage_code_target,
  input  wire       voltage_code_go,
  input  wire       sw_cycle_in,
  input  wire       overtemp_in,
  input  wire       ch3_overcurrent_in,
  input  wire       ch2_overcurrent_in,
  input  wire       ch1_overcurrent_in,
  input  wire       overtemp_warning_in,
  input  wire       ch3_in_window_in,
  input  wire       ch2_in_window_in,
  input  wire       ch1_in_window_in,
  output reg  [7:0] rd_data_ff,
  output reg        rd_valid_ff,
  output reg        ch2_disable_ff,
  output reg        ch2_light_load_select_ff,
  output reg        ch3_disable_ff,
  output reg        ch3_light_load_select_ff,
  output reg  [6:0] voltage_code_ff,
  output reg        code_stepping_ff
);

  // One-hot stepping states
  localparam [1:0] ST_IDLE = 2'h1;
  localparam [1:0] ST_STEP = 2'h2;

  // Cycles per step minus one for a three-bit slew code
  // Code seven shifts the one out, so its limit wraps round to 127
  function [6:0] slew_limit;
    input [2:0] code;
    begin
      slew_limit = (`CCS_STEPCNT_ONE << code) - `CCS_STEPCNT_ONE;
    end
  endfunction

  function addr_hit;
    input [7:0] a;
    input [7:0] ref_a;
    begin
      addr_hit = (a == ref_a);
    end
  endfunction

  reg  [7:0] ch2_cmd_ff;
  reg  [7:0] nxt_ch2_cmd;
  reg  [7:0] ch3_cmd_ff;
  reg  [7:0] nxt_ch3_cmd;
  reg  [7:0] sync1_ff;
  reg  [7:0] status_ff;
  reg        tick_s1_ff;
  reg        tick_s2_ff;
  reg        tick_s3_ff;
  reg  [1:0] state_ff;
  reg  [1:0] nxt_state;
  reg  [6:0] stepcnt_ff;
  reg  [6:0] nxt_stepcnt;
  reg  [6:0] nxt_code;
  reg  [7:0] nxt_rd_data;
  wire       sw_tick;
  wire [7:0] status_raw;

  assign status_raw = {overtemp_in, ch3_overcurrent_in, ch2_overcurrent_in, ch1_overcurrent_in,
                       overtemp_warning_in, ch3_in_window_in, ch2_in_window_in,
                       ch1_in_window_in};
  assign sw_tick = tick_s2_ff & ~tick_s3_ff;

  // Two-stage synchronisers for the analog monitor levels
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_ff  <= `CCS_RST_STATUS;
      status_ff <= `CCS_RST_STATUS;
    end else begin
      sync1_ff  <= status_raw;
      status_ff <= sync1_ff;
    end
  end

  // Switching clock synchroniser; third stage feeds only the edge detector
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tick_s1_ff <= 1'h0;
      tick_s2_ff <= 1'h0;
      tick_s3_ff <= 1'h0;
    end else begin
      tick_s1_ff <= sw_cycle_in;
      tick_s2_ff <= tick_s1_ff;
      tick_s3_ff <= tick_s2_ff;
    end
  end

  // Command register writes
  always @* begin
    nxt_ch2_cmd = ch2_cmd_ff;
    nxt_ch3_cmd = ch3_cmd_ff;
    if (wr_apply && addr_hit(reg_addr, `CCS_ADDR_CH2_CMD)) begin
      nxt_ch2_cmd = wr_data;
    end
    if (wr_apply && addr_hit(reg_addr, `CCS_ADDR_CH3_CMD)) begin
      nxt_ch3_cmd = wr_data;
    end
  end

  // Read mux; status register ignores writes
  always @* begin
    nxt_rd_data = `CCS_RD_UNMAPPED;
    if (addr_hit(reg_addr, `CCS_ADDR_CH2_CMD)) begin
      nxt_rd_data = ch2_cmd_ff;
    end else if (addr_hit(reg_addr, `CCS_ADDR_CH3_CMD)) begin
      nxt_rd_data = ch3_cmd_ff;
    end else if (addr_hit(reg_addr, `CCS_ADDR_STATUS)) begin
      nxt_rd_data = status_ff;
    end
  end

  // Voltage code stepping
  always @* begin
    nxt_state   = state_ff;
    nxt_stepcnt = stepcnt_ff;
    nxt_code    = voltage_code_ff;
    case (state_ff)
      ST_IDLE: begin
        nxt_stepcnt = `CCS_STEPCNT_ZERO;
        // target only followed once go is set
        if (voltage_code_go && (voltage_code_target != voltage_code_ff)) begin
          nxt_state = ST_STEP;
        end
      end
      // A moved target redirects the next step; go low abandons the transition
      ST_STEP: begin
        if (!voltage_code_go || (voltage_code_target == voltage_code_ff)) begin
          nxt_state = ST_IDLE;
        end else if (sw_tick) begin
          // cycles per step from slew code
          if (stepcnt_ff >= slew_limit(ch2_cmd_ff[`CCS_F_SLEW_HI:`CCS_F_SLEW_LO])) begin
            nxt_stepcnt = `CCS_STEPCNT_ZERO;
            // one 10 mV code step toward target
            if (voltage_code_target > voltage_code_ff) begin
              nxt_code = voltage_code_ff + `CCS_CODE_ONE;
            end else begin
              nxt_code = voltage_code_ff - `CCS_CODE_ONE;
            end
          end else begin
            nxt_stepcnt = stepcnt_ff + `CCS_STEPCNT_ONE;
          end
        end
      end
      default: begin
        nxt_state   = ST_IDLE;
        nxt_stepcnt = `CCS_STEPCNT_ZERO;
      end
    endcase
  end

  // Command registers; control outputs follow the value being written
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ch2_cmd_ff               <= `CCS_RST_CH2_CMD;
      ch3_cmd_ff               <= `CCS_RST_CH3_CMD;
      ch2_disable_ff           <= 1'h0;
      ch2_light_load_select_ff <= 1'h0;
      ch3_disable_ff           <= 1'h0;
      ch3_light_load_select_ff <= 1'h0;
    end else begin
      ch2_cmd_ff               <= nxt_ch2_cmd;
      ch3_cmd_ff               <= nxt_ch3_cmd;
      ch2_disable_ff           <= nxt_ch2_cmd[`CCS_F_DISABLE];
      ch2_light_load_select_ff <= nxt_ch2_cmd[`CCS_F_LIGHT_LOAD];
      ch3_disable_ff           <= nxt_ch3_cmd[`CCS_F_DISABLE];
      ch3_light_load_select_ff <= nxt_ch3_cmd[`CCS_F_LIGHT_LOAD];
    end
  end

  // Read port; data holds until the next request
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_ff  <= `CCS_RD_UNMAPPED;
      rd_valid_ff <= 1'h0;
    end else begin
      rd_valid_ff <= rd_req;
      if (rd_req) begin
        rd_data_ff <= nxt_rd_data;
      end
    end
  end

  // Stepping state and the current voltage code
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff         <= ST_IDLE;
      stepcnt_ff       <= `CCS_STEPCNT_ZERO;
      voltage_code_ff  <= `CCS_RST_CODE;
      code_stepping_ff <= 1'h0;
    end else begin
      state_ff         <= nxt_state;
      stepcnt_ff       <= nxt_stepcnt;
      voltage_code_ff  <= nxt_code;
      code_stepping_ff <= (nxt_state == ST_STEP);
    end
  end

endmodule // ccs_regs

// *** test/ccs_chk.sv ***
// Port checker for the command and status bank
`timescale 1ns/10ps
module ccs_chk (
  input wire       mclk,
  input wire       rst_n,
  input wire       wr_apply,
  input wire [7:0] reg_addr,
  input wire [7:0] wr_data,
  input wire       rd_req,
  input wire [6:0] voltage_code_target,
  input wire       voltage_code_go,
  input wire [7:0] rd_data_ff,
  input wire       rd_valid_ff,
  input wire       ch2_disable_ff,
  input wire       ch2_light_load_select_ff,
  input wire       ch3_disable_ff,
  input wire       ch3_light_load_select_ff,
  input wire [6:0] voltage_code_ff,
  input wire       code_stepping_ff
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_rdv; rd_req |=> rd_valid_ff; endproperty
  a_rdv: assert property (p_rdv) else $error("read late");
  property p_wr2; wr_apply && reg_addr == 8'h04 |=>
    {ch2_light_load_select_ff, ch2_disable_ff} == $past(wr_data[1:0]); endproperty
  a_wr2: assert property (p_wr2) else $error("ch2 cmd");
  property p_wr3; wr_apply && reg_addr == 8'h05 |=>
    {ch3_light_load_select_ff, ch3_disable_ff} == $past(wr_data[1:0]); endproperty
  a_wr3: assert property (p_wr3) else $error("ch3 cmd");
  property p_unm; rd_req && (reg_addr < 8'h04 || reg_addr > 8'h06) |=>
    rd_data_ff == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read");
  property p_step; $changed(voltage_code_ff) |-> $past(voltage_code_go) &&
    voltage_code_ff - $past(voltage_code_ff) ==
    ($past(voltage_code_target) > $past(voltage_code_ff) ? 7'h01 : 7'h7F); endproperty
  a_step: assert property (p_step) else $error("bad step");
  property p_go; !$past(voltage_code_go) |-> $stable(voltage_code_ff); endproperty
  a_go: assert property (p_go) else $error("step without go");
  property p_start; voltage_code_go && voltage_code_target != voltage_code_ff |=>
    code_stepping_ff; endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_stop; !voltage_code_go || voltage_code_ff == voltage_code_target |=>
    !code_stepping_ff; endproperty
  a_stop: assert property (p_stop) else $error("no stop");
endmodule // ccs_chk
bind ccs_regs ccs_chk u_chk (.*);

// *** test/ccs_host.sv ***
// Register-port controller model
`timescale 1ns/10ps
module ccs_host (
  input  wire       mclk,
  input  wire       rd_valid_ff,
  input  wire [7:0] rd_data_ff,
  output reg        wr_apply = 1'b0,
  output reg        rd_req = 1'b0,
  output reg  [7:0] reg_addr = 8'h00,
  output reg  [7:0] wr_data = 8'h00
);
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge mclk);
      wr_apply <= 1'b1;
      reg_addr <= a;
      wr_data <= d;
      @(posedge mclk);
      wr_apply <= 1'b0;
      wr_data <= ~d;
    end
  endtask
  task rd(input [7:0] a, output [7:0] d);
    begin
      @(posedge mclk);
      rd_req <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      rd_req <= 1'b0;
      reg_addr <= ~a;
      #1;
      d = rd_valid_ff ? rd_data_ff : 8'hXX;
    end
  endtask
endmodule // ccs_host

// *** test/ccs_regs_tb.sv ***
// Self-checking bench for the command and status bank
`timescale 1ns/10ps
module ccs_regs_tb;
  reg        mclk = 1'b0;
  reg        rst_n = 1'b0;
  reg  [6:0] voltage_code_target = 7'h00;
  reg        voltage_code_go = 1'b0;
  reg        sw_cycle_in = 1'b0;
  reg  [7:0] mon = 8'h00;
  wire [7:0] rd_data_ff, reg_addr, wr_data;
  wire [6:0] voltage_code_ff;
  wire       rd_valid_ff, wr_apply, rd_req, code_stepping_ff;
  wire       ch2_disable_ff, ch2_light_load_select_ff, ch3_disable_ff, ch3_light_load_select_ff;
  reg  [27:0] rows [0:6];
  reg  [7:0] d;
  integer    n_fail = 0, comparisons = 0, i;
  always #2.5 mclk = ~mclk;
  ccs_host u_host (.*);
  ccs_regs u_dut (.*, .overtemp_in(mon[7]), .ch3_overcurrent_in(mon[6]),
    .ch2_overcurrent_in(mon[5]), .ch1_overcurrent_in(mon[4]), .overtemp_warning_in(mon[3]),
    .ch3_in_window_in(mon[2]), .ch2_in_window_in(mon[1]), .ch1_in_window_in(mon[0]));
  task chk(input [7:0] got, input [7:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task sw(input integer n);
    begin
      repeat (n) begin
        @(posedge mclk) sw_cycle_in <= 1'b1;
        repeat (3) @(posedge mclk);
        sw_cycle_in <= 1'b0;
        repeat (3) @(posedge mclk);
      end
      repeat (6) @(posedge mclk);
    end
  endtask
  task finish_test;
    begin
      if (n_fail == 0 && comparisons > 0) begin
        $display("All tests passed");
      end else begin
        $display("Some tests failed");
      end
      $finish;
    end
  endtask
  initial begin
    #100000;
    n_fail = n_fail + 1;
    finish_test;
  end
  initial begin
    rows[0] = {8'h04, 8'h12, 8'h12, 4'h2};
    rows[1] = {8'h04, 8'h71, 8'h71, 4'h1};
    rows[2] = {8'h05, 8'h03, 8'h03, 4'hD};
    rows[3] = {8'h05, 8'hFE, 8'hFE, 4'h9};
    rows[4] = {8'h06, 8'hFF, 8'h00, 4'h9};
    rows[5] = {8'h07, 8'hAA, 8'h00, 4'h9};
    rows[6] = {8'h04, 8'h00, 8'h00, 4'h8};
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    for (i = 0; i < 7; i = i + 1) begin
      u_host.wr(rows[i][27:20], rows[i][19:12]);
      u_host.rd(rows[i][27:20], d);
      chk(d, rows[i][11:4]);
      chk({4'h0, ch3_light_load_select_ff, ch3_disable_ff, ch2_light_load_select_ff,
        ch2_disable_ff}, {4'h0, rows[i][3:0]});
    end
    for (i = 0; i < 2; i = i + 1) begin
      @(posedge mclk) mon <= i ? 8'h5A : 8'hA5;
      repeat (4) @(posedge mclk);
      u_host.rd(8'h06, d);
      chk(d, i ? 8'h5A : 8'hA5);
    end
    @(posedge mclk) voltage_code_go <= 1'h1;
    for (i = 0; i < 8; i = i + 1) begin
      u_host.wr(8'h04, {1'b0, i[2:0], 4'h0});
      voltage_code_target <= i[6:0] + 7'h01;
      sw((1 << i) - 1);
      chk(voltage_code_ff, i[7:0]);
      chk({7'h00, code_stepping_ff}, 8'h01);
      sw(1);
      chk(voltage_code_ff, i[7:0] + 8'h01);
      chk({7'h00, code_stepping_ff}, 8'h00);
    end
    u_host.wr(8'h04, 8'h00);
    voltage_code_go <= 1'b0;
    voltage_code_target <= 7'h00;
    sw(2);
    chk(voltage_code_ff, 8'h08);
    voltage_code_go <= 1'b1;
    sw(1);
    chk(voltage_code_ff, 8'h07);
    @(posedge mclk) rst_n <= 1'b0;
    mon <= 8'h00;
    voltage_code_go <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    chk(voltage_code_ff, 8'h00);
    chk({2'h0, code_stepping_ff, rd_valid_ff, ch3_light_load_select_ff, ch3_disable_ff,
      ch2_light_load_select_ff, ch2_disable_ff}, 8'h00);
    for (i = 4; i < 7; i = i + 1) begin
      u_host.rd(i[7:0], d);
      chk(d, 8'h00);
    end
    finish_test;
  end
endmodule // ccs_regs_tb
